// [adc_mode_pkg.sv]
package adc_mode_pkg;
	localparam int          NUM_CHANNELS   = 8;
	localparam logic [7:0]  CONV_TIME_BASE = 8'h30;
	localparam logic [7:0]  MODE_BASE      = 8'h38;
	localparam logic [7:0]  CONV_TIME_RST  = 8'h91;
	localparam logic [7:0]  MODE_RST       = 8'h00;
	localparam int          CHOPPING_ENABLE_BIT       = 7;
	localparam int          MODE_HI        = 7;
	localparam int          MODE_LO        = 5;
	localparam int          CLOCK_OUTPUT_DISABLE_BIT     = 4;
	localparam int          WIDTH_BIT      = 1;
	localparam int          CLAMP_BIT      = 0;
	localparam logic [17:0] CHOPPING_ENABLE_MUL_SHIFT = 18'd7;
	localparam logic [17:0] NOCHOP_SHIFT   = 18'd6;
	localparam logic [17:0] CHOPPING_ENABLE_OFS_ONE   = 18'd262;
	localparam logic [17:0] NOCHOP_OFS_ONE = 18'd213;
	localparam logic [7:0]  CAL_SEL_BASE   = 8'h30;

	typedef enum logic [2:0] {
		MODE_IDLE, MODE_CONT, MODE_SINGLE, MODE_STANDBY,
		MODE_SELF_ZERO, MODE_SELF_FULL, MODE_SYS_ZERO, MODE_SYS_FULL
	} op_mode_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic       done;
		logic [2:0] channel;
	} conv_evt_t;
endpackage

// [conv_timer.sv]
module conv_timer
	import adc_mode_pkg::*;
#(
	parameter int CW = 18
) (
	input  wire logic          ref_clk,     // Master clock.
	input  wire logic          resetn,      // Async reset, active low.
	input  wire logic          start,       // Restart count, one cycle.
	input  wire logic          abort,       // Stop counting.
	input  wire logic [7:0]    conv_time,   // Active conversion time reg.
	input  wire logic          multi,       // Two or more channels cycling.
	output logic               done         // Elapsed pulse.
);
	if (CW < 15) begin
		$error("CW too narrow for the longest conversion");
	end

	logic [CW-1:0] cnt_q, cnt_d, len;
	logic          run_q, run_d, done_d;

	always_comb begin
		if (conv_time[CHOPPING_ENABLE_BIT]) begin
			len = CW'(({11'h0, conv_time[6:0]} << CHOPPING_ENABLE_MUL_SHIFT)
				+ CHOPPING_ENABLE_OFS_ONE + {17'h0, multi});
		end else begin
			len = CW'(({11'h0, conv_time[6:0]} << NOCHOP_SHIFT)
				+ NOCHOP_OFS_ONE + {17'h0, multi});
		end
	end

	// Count runs 1..len; done fires on the cycle that reaches len.
	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (abort) begin
			run_d = 1'b0;
		end else if (start) begin
			run_d = 1'b1;
			cnt_d = CW'(1);
		end else if (run_q) begin
			if (cnt_q >= len - CW'(1)) begin
				done_d = 1'b1;
				run_d  = 1'b0;
			end
			cnt_d = cnt_q + CW'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			done  <= done_d;
		end
	end
endmodule

// [adc_conversion_mode_control.sv]
// Function
// - Eight 8-bit RW conversion time registers at 0x30 upward, reset 0x91.
// - Bit 7 enables chopping for that channel, resets to one.
// - Bits 6..0 hold the filter word, reset 0x11.
// - Chopping: filter word*128 plus 262, or 263 when several channels.
// - No chopping: filter word*64 plus 213, or 214 when several channels.
// - One 8-bit RW mode register, written at 0x38..0x3f, reset 0x00.
// - Mode write clears status, raises ready_n, aborts, starts new mode.
// - Mode write latches low two address bits as selector.
// - Bits 7..5 are the mode field; a new value takes effect at once.
// - Modes: idle, continuous, single, standby, four calibrations.
// - Selector means first channel, channel, time setting or channel.
// - Idle after reset; back to idle after calibration or single.
// - Continuous: flag each finished channel, move to next enabled one.
// - Mode bit 1 selects 24-bit data registers, else 16-bit.
// - Clamp bit forces out-of-range data to all zeros or ones.
module adc_conversion_mode_control
	import adc_mode_pkg::*;
#(
	parameter int CHANNELS = NUM_CHANNELS
) (
	input  wire logic                ref_clk,        // Master clock.
	input  wire logic                resetn,         // Async reset, low.
	input  adc_mode_pkg::reg_req_t   req,            // Register access.
	input  wire logic [CHANNELS-1:0] channel_enable, // Continuous enables.
	output logic [7:0]               rdata,          // Read data.
	output logic                     ready_n,        // Ready pin, low.
	output logic [CHANNELS-1:0]      status_ready,   // Per-channel ready.
	output adc_mode_pkg::conv_evt_t  conv_evt,       // Conversion finished.
	output logic [2:0]               active_channel, // Channel converting.
	output logic                     converting,     // Any conversion on.
	output logic                     data_24bit,     // Data width 24.
	output logic                     clamp_enable,   // Clamp out of range.
	output logic                     clock_output_disable // Clock out off.
);
	import adc_mode_pkg::*;

	if (CHANNELS != NUM_CHANNELS) begin
		$error("CHANNELS must match the eight time registers");
	end

	logic [7:0]          ctime_q [CHANNELS];
	logic [7:0]          ctime_d [CHANNELS];
	logic [7:0]          mode_q, mode_d;
	logic [1:0]          sel_q, sel_d;
	logic [2:0]          chan_q, chan_d;
	logic                run_q, run_d;
	logic [CHANNELS-1:0] stat_q, stat_d;
	logic                rdyn_q, rdyn_d;
	logic [7:0]          rdata_d;
	conv_evt_t           evt_d;
	logic                start, abort, done, multi, mode_wr;
	logic [2:0]          next_ch;
	logic [3:0]          n_en;
	op_mode_t            cur_mode, new_mode;

	assign cur_mode = op_mode_t'(mode_q[MODE_HI:MODE_LO]);
	assign new_mode = op_mode_t'(req.wdata[MODE_HI:MODE_LO]);
	// The whole eight-address block selects the mode register; the low
	// two address bits only carry the selector.
	assign mode_wr  = req.wr && (req.addr[7:3] == MODE_BASE[7:3]);

	// The next channel is searched upward with wrap-around; with no other
	// channel enabled the current one simply repeats.
	always_comb begin
		n_en = '0;
		for (int i = 0; i < CHANNELS; i++) begin
			n_en = n_en + {3'h0, channel_enable[i]};
		end
		// The extra cycle per conversion only applies while channels cycle.
		multi = (cur_mode == MODE_CONT) && (n_en > 4'd1);
		next_ch = chan_q;
		for (int k = CHANNELS - 1; k >= 1; k--) begin
			if (channel_enable[3'(chan_q + 3'(k))]) begin
				next_ch = 3'(chan_q + 3'(k));
			end
		end
	end

	always_comb begin
		ctime_d = ctime_q;
		mode_d  = mode_q;
		sel_d   = sel_q;
		chan_d  = chan_q;
		run_d   = run_q;
		stat_d  = stat_q;
		rdyn_d  = rdyn_q;
		evt_d   = '0;
		start   = 1'b0;
		abort   = 1'b0;
		// A time register may change mid-conversion; its length applies now.
		if (req.wr && req.addr[7:3] == CONV_TIME_BASE[7:3]) begin
			ctime_d[req.addr[2:0]] = req.wdata;
		end
		// Completion is handled first so a mode write in the same cycle wins.
		if (done && run_q) begin
			evt_d.done    = 1'b1;
			evt_d.channel = chan_q;
			case (cur_mode)
				MODE_CONT: begin
					stat_d[chan_q] = 1'b1;
					rdyn_d = 1'b0;
					chan_d = next_ch;
					start  = 1'b1;
				end
				MODE_SINGLE: begin
					stat_d[chan_q] = 1'b1;
					rdyn_d = 1'b0;
					run_d  = 1'b0;
					mode_d[MODE_HI:MODE_LO] = MODE_IDLE;
				end
				MODE_SELF_ZERO, MODE_SELF_FULL,
				MODE_SYS_ZERO, MODE_SYS_FULL: begin
					rdyn_d = 1'b0;
					run_d  = 1'b0;
					mode_d[MODE_HI:MODE_LO] = MODE_IDLE;
				end
				default: begin
					// Idle and standby never start the timer.
					run_d = 1'b0;
				end
			endcase
		end
		if (mode_wr) begin
			mode_d = req.wdata;
			sel_d  = req.addr[1:0];
			stat_d = '0;
			rdyn_d = 1'b1;
			abort  = 1'b1;
			// A completion in the same cycle is dropped with the old mode.
			evt_d  = '0;
			chan_d = {1'b0, req.addr[1:0]};
			case (new_mode)
				MODE_CONT, MODE_SINGLE, MODE_SYS_ZERO, MODE_SYS_FULL,
				MODE_SELF_ZERO, MODE_SELF_FULL: begin
					run_d = 1'b1;
					start = 1'b1;
				end
				default: begin
					run_d = 1'b0;
				end
			endcase
		end
	end

	// Reads see registered state only, so a read in the same cycle as a
	// write returns the old value.
	always_comb begin
		rdata_d = rdata;
		if (req.rd) begin
			if (req.addr[7:3] == CONV_TIME_BASE[7:3]) begin
				rdata_d = ctime_q[req.addr[2:0]];
			end else if (req.addr == MODE_BASE) begin
				rdata_d = mode_q;
			end else begin
				// Unmapped addresses and the mode aliases read as zero.
				rdata_d = 8'h00;
			end
		end
	end

	// Self-calibration uses the selected channel's time setting as its
	// conversion length; the other modes time the channel itself.
	logic [7:0] timed;
	always_comb begin
		timed = ctime_q[chan_q];
		if (cur_mode == MODE_SELF_ZERO || cur_mode == MODE_SELF_FULL) begin
			timed = ctime_q[{1'b0, sel_q}];
		end
	end

	// A mode write that starts a mode restarts the timer, not stops it.
	conv_timer u_timer (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.start     (start),
		.abort     (abort && !start),
		.conv_time (timed),
		.multi     (multi),
		.done      (done)
	);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CHANNELS; i++) begin
				ctime_q[i] <= CONV_TIME_RST;
			end
			mode_q   <= MODE_RST;
			sel_q    <= '0;
			chan_q   <= '0;
			run_q    <= 1'b0;
			stat_q   <= '0;
			rdyn_q   <= 1'b1;
			conv_evt <= '0;
		end else begin
			ctime_q  <= ctime_d;
			mode_q   <= mode_d;
			sel_q    <= sel_d;
			chan_q   <= chan_d;
			run_q    <= run_d;
			stat_q   <= stat_d;
			rdyn_q   <= rdyn_d;
			conv_evt <= evt_d;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdata_d;
		end
	end

	assign ready_n              = rdyn_q;
	assign status_ready         = stat_q;
	assign active_channel       = chan_q;
	assign converting           = run_q;
	assign data_24bit           = mode_q[WIDTH_BIT];
	assign clamp_enable         = mode_q[CLAMP_BIT];
	assign clock_output_disable = mode_q[CLOCK_OUTPUT_DISABLE_BIT];
endmodule

// [adc_mode_monitor.sv]
module adc_mode_monitor
	import adc_mode_pkg::*;
#(parameter int CHANNELS = 8) (
	input wire logic                ref_clk,        // Clock.
	input wire logic                resetn,         // Reset.
	input adc_mode_pkg::reg_req_t   req,            // Access.
	input wire logic [7:0]          rdata,          // Read data.
	input wire logic                ready_n,        // Ready pin.
	input wire logic [CHANNELS-1:0] status_ready,   // Flags.
	input adc_mode_pkg::conv_evt_t  conv_evt,       // Completion.
	input wire logic [2:0]          active_channel, // Channel.
	input wire logic                converting,     // Busy.
	input wire logic                data_24bit,     // Width.
	input wire logic                clamp_enable,   // Clamp.
	input wire logic                clock_output_disable // Clock off.
);
	wire       mw = req.wr && req.addr[7:3] == MODE_BASE[7:3];
	wire [2:0] md = req.wdata[7:5];
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	chk_wr_ready_high: assert property
		(mw |=> ready_n)
		else $error("ready_n low after mode write");
	chk_wr_status_clr: assert property
		(mw |=> status_ready == '0)
		else $error("status kept after mode write");
	chk_done_ready: assert property
		(conv_evt.done && !mw |-> ##[0:1] !ready_n)
		else $error("ready_n not low at completion");
	chk_done_once: assert property
		(conv_evt.done |=> !conv_evt.done)
		else $error("completion pulse too long");
	chk_refused_rd: assert property
		(req.rd && req.addr[7:3] == MODE_BASE[7:3] &&
		req.addr[2:0] != 3'h0 |=> rdata == 8'h00)
		else $error("alias read not zero");
	chk_mode_bits: assert property
		(mw |=> {clock_output_disable, data_24bit, clamp_enable} ==
		{$past(req.wdata[4]), $past(req.wdata[1:0])})
		else $error("mode bits not taken");
	chk_start_sel: assert property
		(mw && md == 3'b010 |=> converting &&
		active_channel == {1'b0, $past(req.addr[1:0])})
		else $error("single start wrong");
	chk_idle_quiet: assert property
		(mw && (md == 3'b000 || md == 3'b011) |=> !converting)
		else $error("converting in idle or standby");
	cov_single: cover property (mw && md == 3'b010);
	cov_cont: cover property (mw && md == 3'b001);
	cov_cal: cover property (mw && md[2]);
	cov_done: cover property (conv_evt.done);
endmodule
bind adc_conversion_mode_control adc_mode_monitor #(.CHANNELS(CHANNELS))
	mon (
	.ref_clk              (ref_clk),
	.resetn               (resetn),
	.req                  (req),
	.rdata                (rdata),
	.ready_n              (ready_n),
	.status_ready         (status_ready),
	.conv_evt             (conv_evt),
	.active_channel       (active_channel),
	.converting           (converting),
	.data_24bit           (data_24bit),
	.clamp_enable         (clamp_enable),
	.clock_output_disable (clock_output_disable)
);

// [host_model.sv]
module host_model
	import adc_mode_pkg::*;
(
	input  wire logic          ref_clk, // Clock.
	input  wire logic [7:0]    rdata,   // Read data.
	output adc_mode_pkg::reg_req_t req  // Access.
);
	initial req = '{1'b0, 1'b0, 8'hff, 8'hff};
	// Released fields show inverted values so stale data cannot pass.
	task automatic xfer(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		@(posedge ref_clk);
		#1 req = '{w, !w, a, d};
		@(posedge ref_clk);
		#1 req = '{1'b0, 1'b0, ~a, ~d};
		q = rdata;
	endtask
endmodule

// [adc_conversion_mode_control_tb.sv]
module adc_conversion_mode_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_mode_pkg::*;
	logic       ref_clk = 0;
	logic       resetn = 0;
	logic [7:0] channel_enable = 8'h00;
	logic [7:0] rdata, status_ready, q;
	logic [2:0] active_channel;
	logic       ready_n, converting, data_24bit, clamp_enable;
	logic       clock_output_disable;
	reg_req_t   req;
	conv_evt_t  conv_evt;
	int         failures = 0;
	int         compares = 0;
	always #20 ref_clk = ~ref_clk;
	adc_conversion_mode_control uut (
		.ref_clk              (ref_clk),
		.resetn               (resetn),
		.req                  (req),
		.channel_enable       (channel_enable),
		.rdata                (rdata),
		.ready_n              (ready_n),
		.status_ready         (status_ready),
		.conv_evt             (conv_evt),
		.active_channel       (active_channel),
		.converting           (converting),
		.data_24bit           (data_24bit),
		.clamp_enable         (clamp_enable),
		.clock_output_disable (clock_output_disable)
	);
	host_model host (
		.ref_clk (ref_clk),
		.rdata   (rdata),
		.req     (req)
	);
	task automatic check(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("compares=%0d failures=%0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, d);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		host.xfer(1'b0, a, 8'h00, q);
	endtask
	// A conversion of len cycles completes len edges after its start edge;
	// the first wait also skips a completion pulse still standing.
	task automatic await(input int len, input logic [2:0] ch);
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while (conv_evt.done !== 1'b1 && n < 20000);
		check(n, len);
		check(conv_evt.channel, ch);
	endtask
	task automatic run(input logic [7:0] a, m, input int len);
		wr(a, m);
		check({converting, active_channel}, {2'b10, a[1:0]});
		await(len, a[2:0] & 3'h3);
		@(posedge ref_clk);
		#1 check({ready_n, converting}, 2'b00);
		rd(8'h38);
		check(q, {3'b000, m[4:0]});
	endtask
	task automatic t_regs;
		for (int i = 0; i < 8; i++) begin
			rd(8'h30 + i[7:0]);
			check(q, 8'h91);
			wr(8'h30 + i[7:0], 8'h5a ^ i[7:0]);
			rd(8'h30 + i[7:0]);
			check(q, 8'h5a ^ i[7:0]);
		end
		rd(8'h38);
		check(q, 8'h00);
		wr(8'h40, 8'hff);
		rd(8'h40);
		check(q, 8'h00);
		rd(8'h39);
		check(q, 8'h00);
		$display("registers done");
	endtask
	task automatic t_single;
		wr(8'h32, 8'h82);
		run(8'h3a, 8'h40, 2 * 128 + 262);
		check(status_ready[2], 1'b1);
		wr(8'h31, 8'h03);
		run(8'h3d, 8'h43, 3 * 64 + 213);
		check({data_24bit, clamp_enable}, 2'b11);
		wr(8'h33, 8'h7f);
		run(8'h3b, 8'h40, 127 * 64 + 213);
		$display("single done");
	endtask
	task automatic t_cont;
		wr(8'h30, 8'h82);
		wr(8'h31, 8'h82);
		channel_enable = 8'h03;
		wr(8'h38, 8'h20);
		await(2 * 128 + 263, 3'd0);
		await(2 * 128 + 263, 3'd1);
		check(status_ready, 8'h03);
		wr(8'h38, 8'h00);
		check({ready_n, status_ready, converting}, 10'h200);
		channel_enable = 8'h00;
		$display("continuous done");
	endtask
	task automatic t_cal;
		for (int m = 4; m < 8; m++)
			run(8'h3a, {m[2:0], 5'h00}, 2 * 128 + 262);
		$display("calibration done");
	endtask
	task automatic t_standby;
		wr(8'h38, 8'h73);
		repeat (600) @(posedge ref_clk);
		#1 check({converting, conv_evt.done}, 2'b00);
		check({clock_output_disable, data_24bit, clamp_enable}, 3'h7);
		rd(8'h38);
		check(q, 8'h73);
		$display("standby done");
	endtask
	// Reset in the middle of a continuous run must bring back idle.
	task automatic t_reset;
		channel_enable = 8'h01;
		wr(8'h38, 8'h20);
		repeat (5) @(posedge ref_clk);
		#1 resetn = 0;
		@(posedge ref_clk);
		#1 check({ready_n, converting, status_ready}, 10'h200);
		resetn = 1;
		rd(8'h30);
		check(q, 8'h91);
		rd(8'h38);
		check(q, 8'h00);
		channel_enable = 8'h00;
		$display("reset done");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 resetn = 1;
		check(ready_n, 1'b1);
		t_regs;
		t_single;
		t_cont;
		t_cal;
		t_standby;
		t_reset;
		summarize;
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		failures++;
		summarize;
	end
endmodule
